// [core/bcc_pkg.sv]
// package for the bus control configuration register bank
package bcc_pkg;
  // register byte offsets on the avalon slave (word aligned)
  localparam logic [3:0] BCC_OFS_BUS_CTRL  = 4'h0;
  localparam logic [3:0] BCC_OFS_CS_CTRL   = 4'h4;
  localparam logic [3:0] BCC_OFS_ADDR_CTRL = 4'h8;
  localparam logic [3:0] BCC_OFS_STATUS    = 4'hc;

  // reset values
  localparam logic [7:0] BCC_RST_BUS_CTRL  = 8'hc6;
  localparam logic [7:0] BCC_RST_CS_CTRL   = 8'h0f;
  localparam logic [7:0] BCC_RST_ADDR_CTRL = 8'hff;

  // field positions
  localparam int BCC_BIT_IDLE_DIFF  = 7;
  localparam int BCC_BIT_IDLE_RW    = 6;
  localparam int BCC_BIT_FIXED_ONE  = 2;
  localparam int BCC_BIT_SPLIT      = 1;
  localparam int BCC_BIT_WAIT_EN    = 0;
  localparam int BCC_BIT_ADDR_UPD   = 0;

  // writable masks; fixed-one masks
  localparam logic [7:0] BCC_WMASK_BUS_CTRL  = 8'hfb;
  localparam logic [7:0] BCC_ONES_BUS_CTRL   = 8'h04;
  localparam logic [7:0] BCC_WMASK_CS_CTRL   = 8'hf0;
  localparam logic [7:0] BCC_ONES_CS_CTRL    = 8'h0f;
  localparam logic [7:0] BCC_WMASK_ADDR_CTRL = 8'h01;
  localparam logic [7:0] BCC_ONES_ADDR_CTRL  = 8'hfe;
  localparam logic [7:0] BCC_ALL_ONES        = 8'hff;

  // operating modes honouring the area split
  localparam logic [2:0] BCC_MODE_EXP_A = 3'h3;
  localparam logic [2:0] BCC_MODE_EXP_B = 3'h4;
  localparam logic [2:0] BCC_MODE_EXP_C = 3'h5;

  // unequal area map bounds (24-bit address)
  localparam logic [23:0] BCC_A1_BASE = 24'h200000;
  localparam logic [23:0] BCC_A2_BASE = 24'h400000;
  localparam logic [23:0] BCC_A3_BASE = 24'hc00000;
  localparam logic [23:0] BCC_A4_BASE = 24'he00000;
  localparam logic [23:0] BCC_A5_BASE = 24'hfee000;
  localparam logic [23:0] BCC_A6_BASE = 24'hfef000;
  localparam logic [23:0] BCC_A7_BASE = 24'hffffea;
  localparam int          BCC_EQ_MSB  = 23;
  localparam int          BCC_EQ_LSB  = 21;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       external;
    logic [23:0] addr;
  } bcc_cycle_t;

  typedef struct packed {
    logic       idle_diff_area_read;
    logic       idle_read_then_write;
    logic       area_split_select;
    logic       wait_pin_enable;
    logic       addr_update_select;
  } bcc_cfg_t;
endpackage

// [core/bcc_area_decode.sv]
// area number decoder for the external address space
`timescale 1ns/10ps
module bcc_area_decode (
  input  wire logic [23:0] addr,
  input  wire logic        unequal,
  output logic      [2:0]  area
);
  import bcc_pkg::*;

  always_comb begin
    if (!unequal) begin
      area = addr[BCC_EQ_MSB:BCC_EQ_LSB];
    end else if (addr >= BCC_A7_BASE) begin
      area = 3'h7;
    end else if (addr >= BCC_A6_BASE) begin
      area = 3'h6;
    end else if (addr >= BCC_A5_BASE) begin
      area = 3'h5;
    end else if (addr >= BCC_A4_BASE) begin
      area = 3'h4;
    end else if (addr >= BCC_A3_BASE) begin
      area = 3'h3;
    end else if (addr >= BCC_A2_BASE) begin
      area = 3'h2;
    end else if (addr >= BCC_A1_BASE) begin
      area = 3'h1;
    end else begin
      area = 3'h0;
    end
  end
endmodule

// [core/bcc_regs.sv]
// bus control configuration registers with avalon slave and bus effects
`timescale 1ns/10ps
// What this block does
// RQ1 - bus control resets to c6, keeps in standby
// RQ2 - idle after reads to different areas
// RQ3 - idle between read and following write
// RQ4 - software never writes ones to bits 5-3
// RQ5 - bus control bit 2 reads one
// RQ6 - split set: eight equal 2 MB areas
// RQ7 - split clear: unequal area map
// RQ8 - split honoured only in modes 3-5
// RQ9 - wait pin used only when enabled
// RQ10 - select enable overrides pin function
// RQ11 - selects off at reset; single-chip blocks writes
// RQ12 - chip select control resets to 0f
// RQ13 - chip select low bits read ones
// RQ14 - address control resets to ff
// RQ15 - update select: 1 mode1, 0 mode2
// RQ16 - address control upper bits read one
// RQ17 - variant without register reads ff
// RQ18 - mode 1 updates address every cycle
// RQ19 - mode 2 updates only external cycles
// RQ20 - wait pin stretches three-state access
module bcc_regs #(
  parameter bit HAS_ADDR_CTRL = 1'b1
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                hw_standby,
  input  wire logic [2:0]          op_mode,
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire bcc_pkg::bcc_cycle_t cyc_in,
  input  wire logic                cyc_three_state,
  input  wire logic                wait_n_pin,
  output logic                     cyc_ready,
  output logic                     idle_insert,
  output logic      [2:0]          cur_area,
  output logic      [23:0]         addr_out,
  output logic      [3:0]          upper_select_out_enable,
  output logic      [3:0]          upper_area_select_n,
  output logic                     wait_pin_as_port,
  output bcc_pkg::bcc_cfg_t        cfg
);
  import bcc_pkg::*;

  logic [7:0]  bus_control_q;
  logic [7:0]  chip_select_control_q;
  logic [7:0]  address_output_control_q;
  logic        ack_q;
  logic        wait_s1_q;
  logic        wait_s2_q;
  logic        prev_valid_q;
  logic        prev_read_q;
  logic [2:0]  prev_area_q;
  logic        single_chip;
  logic        expanded16;
  logic [2:0]  area_d;
  logic        wr_fire;
  logic        rd_fire;
  logic        stretch;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] wmask, input logic [7:0] ones);
    merge = (old & ~wmask) | (wd & wmask) | ones;
  endfunction

  // modes 1..5 are expanded; 0, 6 and 7 run single-chip
  assign single_chip = (op_mode > BCC_MODE_EXP_C) || (op_mode == 3'h0);
  // RQ8 split valid
  assign expanded16  = (op_mode == BCC_MODE_EXP_A) || (op_mode == BCC_MODE_EXP_B)
                    || (op_mode == BCC_MODE_EXP_C);

  // one wait state per request; read data loads on the first edge
  // so it already stands at the edge where waitrequest is seen low
  assign wr_fire = avs_write && ack_q;
  assign rd_fire = avs_read && !ack_q;

  always_ff @(posedge clock) begin
    if (!rst_b || hw_standby) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || hw_standby) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // RQ1 reset and write
  always_ff @(posedge clock) begin
    if (!rst_b || hw_standby) begin
      bus_control_q <= BCC_RST_BUS_CTRL;
    end else if (wr_fire && avs_address == BCC_OFS_BUS_CTRL && avs_byteenable[0]) begin
      // RQ5 bit two fixed
      bus_control_q <= merge(bus_control_q, avs_writedata[7:0],
                             BCC_WMASK_BUS_CTRL, BCC_ONES_BUS_CTRL);
    end
  end

  // RQ12 reset and write
  always_ff @(posedge clock) begin
    if (!rst_b || hw_standby) begin
      chip_select_control_q <= BCC_RST_CS_CTRL;
    end else if (wr_fire && avs_address == BCC_OFS_CS_CTRL && avs_byteenable[0]
                 && !single_chip) begin
      // RQ11 single-chip lock, RQ13 low ones
      chip_select_control_q <= merge(chip_select_control_q, avs_writedata[7:0],
                                     BCC_WMASK_CS_CTRL, BCC_ONES_CS_CTRL);
    end
  end

  // RQ14 reset and write
  always_ff @(posedge clock) begin
    if (!rst_b || hw_standby) begin
      address_output_control_q <= BCC_RST_ADDR_CTRL;
    end else if (wr_fire && avs_address == BCC_OFS_ADDR_CTRL && avs_byteenable[0]
                 && HAS_ADDR_CTRL) begin
      // RQ16 upper ones, RQ17 absent variant
      address_output_control_q <= merge(address_output_control_q, avs_writedata[7:0],
                                        BCC_WMASK_ADDR_CTRL, BCC_ONES_ADDR_CTRL);
    end
  end

  // RQ17 read returns ff
  always_ff @(posedge clock) begin
    if (!rst_b || hw_standby) begin
      avs_readdata <= '0;
    end else if (rd_fire) begin
      unique case (avs_address)
        BCC_OFS_BUS_CTRL:  avs_readdata <= {24'h0, bus_control_q};
        BCC_OFS_CS_CTRL:   avs_readdata <= {24'h0, chip_select_control_q};
        BCC_OFS_ADDR_CTRL: avs_readdata <= {24'h0, HAS_ADDR_CTRL ? address_output_control_q
                                                                 : BCC_ALL_ONES};
        BCC_OFS_STATUS:    avs_readdata <= {28'h0, stretch, single_chip, expanded16, idle_insert};
        default:           avs_readdata <= '0;
      endcase
    end
  end

  // RQ20 two-flop sync of wait pin
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wait_s1_q <= 1'b1;
      wait_s2_q <= 1'b1;
    end else begin
      wait_s1_q <= wait_n_pin;
      wait_s2_q <= wait_s1_q;
    end
  end

  // RQ9 wait only when enabled, RQ20 three-state only
  assign stretch = bus_control_q[BCC_BIT_WAIT_EN] && !wait_s2_q && cyc_three_state
                && cyc_in.valid && cyc_in.external;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cyc_ready <= 1'b0;
    end else begin
      cyc_ready <= cyc_in.valid && !stretch;
    end
  end

  bcc_area_decode u_dec (
    .addr    (cyc_in.addr),
    // RQ6 RQ7 split select
    .unequal (expanded16 && !bus_control_q[BCC_BIT_SPLIT]),
    .area    (area_d)
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prev_valid_q <= 1'b0;
      prev_read_q  <= 1'b0;
      prev_area_q  <= '0;
    end else if (cyc_in.valid && cyc_in.external && !stretch) begin
      prev_valid_q <= 1'b1;
      prev_read_q  <= !cyc_in.write;
      prev_area_q  <= area_d;
    end else if (cyc_in.valid && !cyc_in.external) begin
      prev_valid_q <= 1'b0;
    end
  end

  // RQ2 RQ3 idle insertion
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      idle_insert <= 1'b0;
    end else begin
      idle_insert <= cyc_in.valid && cyc_in.external && prev_valid_q && prev_read_q
        && ((bus_control_q[BCC_BIT_IDLE_DIFF] && !cyc_in.write && area_d != prev_area_q)
         || (bus_control_q[BCC_BIT_IDLE_RW] && cyc_in.write));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cur_area <= '0;
    end else if (cyc_in.valid && cyc_in.external) begin
      cur_area <= area_d;
    end
  end

  // RQ18 RQ19 address update modes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      addr_out <= '0;
    end else if (cyc_in.valid && (cyc_in.external
                 || address_output_control_q[BCC_BIT_ADDR_UPD])) begin
      addr_out <= cyc_in.addr;
    end
  end

  // RQ10 enables override, RQ11 disabled at reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      upper_select_out_enable <= '0;
      upper_area_select_n     <= 4'hf;
    end else begin
      upper_select_out_enable <= chip_select_control_q[7:4];
      for (int i = 0; i < 4; i++) begin
        upper_area_select_n[i] <= !(cyc_in.valid && cyc_in.external
                                    && area_d == 3'(i + 4));
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wait_pin_as_port <= 1'b1;
      cfg              <= '0;
    end else begin
      wait_pin_as_port         <= !bus_control_q[BCC_BIT_WAIT_EN];
      cfg.idle_diff_area_read  <= bus_control_q[BCC_BIT_IDLE_DIFF];
      cfg.idle_read_then_write <= bus_control_q[BCC_BIT_IDLE_RW];
      cfg.area_split_select    <= bus_control_q[BCC_BIT_SPLIT];
      cfg.wait_pin_enable      <= bus_control_q[BCC_BIT_WAIT_EN];
      cfg.addr_update_select   <= address_output_control_q[BCC_BIT_ADDR_UPD];
    end
  end

  // RQ5 bit two reads one
  a_bus_ctrl_fixed: assert property (@(posedge clock) disable iff (!rst_b) // RQ5
    bus_control_q[BCC_BIT_FIXED_ONE]) else $error("bus control bit 2 not one");
  // RQ13 low bits ones
  a_cs_low_ones: assert property (@(posedge clock) disable iff (!rst_b) // RQ13
    chip_select_control_q[3:0] == 4'hf) else $error("cs control low bits not ones");
  // RQ16 upper bits ones
  a_addr_upper_ones: assert property (@(posedge clock) disable iff (!rst_b) // RQ16
    address_output_control_q[7:1] == 7'h7f) else $error("addr control upper bits");
  // RQ11 write lock
  a_cs_lock: assert property (@(posedge clock) disable iff (!rst_b) // RQ11
    single_chip && !hw_standby |=> $stable(chip_select_control_q))
    else $error("cs control changed in single-chip");
  // RQ1 standby reset
  a_bus_standby: assert property (@(posedge clock) disable iff (!rst_b) // RQ1
    hw_standby |=> bus_control_q == BCC_RST_BUS_CTRL) else $error("bus control not reset");
  // RQ19 mode two hold
  a_addr_hold: assert property (@(posedge clock) disable iff (!rst_b) // RQ19
    !address_output_control_q[BCC_BIT_ADDR_UPD] && cyc_in.valid && !cyc_in.external
    |=> $stable(addr_out)) else $error("address moved on internal cycle");
  // RQ18 mode one update
  a_addr_update: assert property (@(posedge clock) disable iff (!rst_b) // RQ18
    address_output_control_q[BCC_BIT_ADDR_UPD] && cyc_in.valid
    |=> addr_out == $past(cyc_in.addr)) else $error("address not updated");
  // RQ9 wait ignored when off
  a_wait_off: assert property (@(posedge clock) disable iff (!rst_b) // RQ9
    !bus_control_q[BCC_BIT_WAIT_EN] && cyc_in.valid |=> cyc_ready)
    else $error("wait honoured while disabled");
  // RQ10 enables follow register
  a_cs_enable: assert property (@(posedge clock) disable iff (!rst_b) // RQ10
    ##1 upper_select_out_enable == $past(chip_select_control_q[7:4]))
    else $error("select enable mismatch");
  // RQ12 chip select standby reset
  a_cs_standby: assert property (@(posedge clock) disable iff (!rst_b) // RQ12
    hw_standby |=> chip_select_control_q == BCC_RST_CS_CTRL)
    else $error("chip select control not reset");
  // RQ14 address control standby reset
  a_addr_standby: assert property (@(posedge clock) disable iff (!rst_b) // RQ14
    hw_standby |=> address_output_control_q == BCC_RST_ADDR_CTRL)
    else $error("address control not reset");
  // RQ3 idle before write
  a_idle_rw: assert property (@(posedge clock) disable iff (!rst_b) // RQ3
    cyc_in.valid && cyc_in.external && cyc_in.write && prev_valid_q && prev_read_q
    && bus_control_q[BCC_BIT_IDLE_RW] |=> idle_insert) else $error("no idle before write");
  // RQ2 idle between area reads
  a_idle_diff: assert property (@(posedge clock) disable iff (!rst_b) // RQ2
    cyc_in.valid && cyc_in.external && !cyc_in.write && prev_valid_q && prev_read_q
    && bus_control_q[BCC_BIT_IDLE_DIFF] && area_d != prev_area_q |=> idle_insert)
    else $error("no idle between reads of two areas");
  // RQ20 wait low stretches
  a_wait_stretch: assert property (@(posedge clock) disable iff (!rst_b) // RQ20
    bus_control_q[BCC_BIT_WAIT_EN] && !wait_s2_q && cyc_three_state && cyc_in.valid
    && cyc_in.external |=> !cyc_ready) else $error("access not stretched");
  // RQ8 split ignored outside modes
  a_split_ignored: assert property (@(posedge clock) disable iff (!rst_b) // RQ8
    !expanded16 && cyc_in.valid && cyc_in.external
    |=> cur_area == $past(cyc_in.addr[BCC_EQ_MSB:BCC_EQ_LSB]))
    else $error("area split used outside its modes");
  // RQ11 selects off after standby
  a_sel_off_standby: assert property (@(posedge clock) disable iff (!rst_b) // RQ11
    hw_standby |-> ##2 upper_select_out_enable == 4'h0)
    else $error("select enable left on after standby");
endmodule

// [bench/bcc_ext_mem.sv]
// far-side memory model that stretches accesses through the wait pin
`timescale 1ns/10ps
module bcc_ext_mem (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       stall_go,
  input  wire logic [3:0] stall_cycles,
  output logic            wait_n_pin
);
  logic [3:0] cnt_q;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
    end else if (stall_go) begin
      cnt_q <= stall_cycles;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // pull-up level once released
  assign wait_n_pin = (cnt_q == 4'h0);
endmodule

// [bench/testbench.sv]
// self-checking bench for the bus control configuration registers
`timescale 1ns/10ps
module testbench;
  import bcc_pkg::*;
  logic        clock = 1'b0, rst_b = 1'b0, hw_standby = 1'b0, cyc_three_state = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0, stall_go = 1'b0;
  logic [2:0]  op_mode = 3'h3;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf, stall_cycles = 4'h8;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, cyc_ready, idle_insert, wait_pin_as_port, wait_n_pin;
  logic [2:0]  cur_area;
  logic [23:0] addr_out;
  logic [3:0]  upper_select_out_enable, upper_area_select_n;
  bcc_cycle_t  cyc_in = '0;
  bcc_cfg_t    cfg;
  logic [7:0]  m [3];
  logic [7:0]  q, q2;
  logic [3:0]  sel;
  logic [31:0] lite_readdata;
  int          error_cnt = 0, total_checks = 0, cyc_cnt = 0;

  bcc_regs uut (.clock(clock), .rst_b(rst_b), .hw_standby(hw_standby), .op_mode(op_mode),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cyc_in(cyc_in),
    .cyc_three_state(cyc_three_state), .wait_n_pin(wait_n_pin), .cyc_ready(cyc_ready),
    .idle_insert(idle_insert), .cur_area(cur_area), .addr_out(addr_out),
    .upper_select_out_enable(upper_select_out_enable),
    .upper_area_select_n(upper_area_select_n), .wait_pin_as_port(wait_pin_as_port), .cfg(cfg));
  bcc_ext_mem far (.clock(clock), .rst_b(rst_b), .stall_go(stall_go),
    .stall_cycles(stall_cycles), .wait_n_pin(wait_n_pin));
  // variant without the address control register, run in lockstep
  bcc_regs #(.HAS_ADDR_CTRL(1'b0)) uut_lite (.clock(clock), .rst_b(rst_b),
    .hw_standby(hw_standby), .op_mode(op_mode), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(lite_readdata), .avs_waitrequest(),
    .cyc_in(cyc_in), .cyc_three_state(cyc_three_state), .wait_n_pin(wait_n_pin),
    .cyc_ready(), .idle_insert(), .cur_area(), .addr_out(), .upper_select_out_enable(),
    .upper_area_select_n(), .wait_pin_as_port(), .cfg());

  always #4 clock = ~clock;
  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t output %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    q = avs_readdata[7:0];
    q2 = lite_readdata[7:0];
    chk_rd(avs_readdata & 32'hffffff00, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [7:0] model(input int r, input logic [7:0] d);
    if (r == 0) return (d & BCC_WMASK_BUS_CTRL) | BCC_ONES_BUS_CTRL;
    if (r == 1) return !(op_mode inside {3'h0, 3'h6, 3'h7}) ? ((d & 8'hf0) | 8'h0f) : m[1];
    return (d & 8'h01) | 8'hfe;
  endfunction
  task automatic wr(input int r, input logic [7:0] d);
    bus(1'b1, 4'(r * 4), d);
    m[r] = model(r, d);
  endtask
  task automatic rd(input int r);
    bus(1'b0, 4'(r * 4), 8'h00);
    chk_rd({24'h0, q}, {24'h0, m[r]});
    if (r == 2) chk_rd({24'h0, q2}, 32'hff);
  endtask
  task automatic pins();
    repeat (2) @(posedge clock);
    chk_pin({upper_select_out_enable, wait_pin_as_port, cfg},
            {m[1][7:4], !m[0][0], m[0][7], m[0][6], m[0][1], m[0][0], m[2][0]});
  endtask
  task automatic pair(input logic w2, input logic e2, input logic [23:0] a1, input logic [23:0] a2);
    cyc_in <= '{1'b1, 1'b0, 1'b1, a1};
    @(posedge clock);
    cyc_in <= '{1'b1, w2, e2, a2};
    @(posedge clock);
    // selects launched by the first cycle
    sel = upper_area_select_n;
    cyc_in <= '0;
    // results of the second cycle are read at this edge
    @(posedge clock);
  endtask

  initial begin
    void'($urandom(1));
    m[0] = 8'hc6;
    m[1] = 8'h0f;
    m[2] = 8'hff;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    for (int r = 0; r < 3; r++) rd(r);
    pins();
    bus(1'b0, BCC_OFS_STATUS, 8'h00);
    chk_rd({24'h0, q}, 32'h2);
    for (int i = 0; i < 12; i++) begin
      // reserved middle bits kept clear
      wr(i % 3, (i % 3 == 0) ? (8'($urandom) & 8'hc7) : 8'($urandom));
      rd(i % 3);
      pins();
    end
    avs_byteenable <= 4'he;
    bus(1'b1, 4'h4, 8'ha0);
    avs_byteenable <= 4'hf;
    rd(1);
    bus(1'b1, 4'h6, 8'h55);
    bus(1'b0, 4'h6, 8'h00);
    chk_rd({24'h0, q}, 32'h0);
    op_mode <= 3'h7;
    wr(1, ~m[1]);
    rd(1);
    op_mode <= 3'h3;
    for (int k = 0; k < 4; k++) begin
      wr(0, {2'(k), 6'h06});
      pair(1'b0, 1'b1, 24'h000000, 24'h200000);
      chk_pin({23'h0, idle_insert}, {23'h0, m[0][7]});
      pair(1'b1, 1'b1, 24'h000000, 24'h000010);
      chk_pin({23'h0, idle_insert}, {23'h0, m[0][6]});
      wr(2, 8'(k[0]));
      pair(1'b0, 1'b0, 24'h123456, 24'h00ab00);
      chk_pin(addr_out, k[0] ? 24'h00ab00 : 24'h123456);
      wr(0, {6'h31, k[1], 1'b0});
      op_mode <= k[0] ? 3'h7 : 3'h5;
      pair(1'b0, 1'b0, 24'hfee100, 24'h0);
      chk_pin({21'h0, cur_area}, (!k[1] && !k[0]) ? 24'h5 : 24'h7);
      chk_pin({20'h0, sel}, (!k[1] && !k[0]) ? 24'hd : 24'h7);
      op_mode <= 3'h3;
    end
    for (int w = 1; w >= 0; w--) begin
      wr(0, {7'h63, w[0]});
      cyc_in <= '{1'b1, 1'b0, 1'b1, 24'h000100};
      cyc_three_state <= 1'b1;
      stall_go <= 1'b1;
      @(posedge clock);
      stall_go <= 1'b0;
      repeat (5) @(posedge clock);
      chk_pin({23'h0, cyc_ready}, {23'h0, !w[0]});
      repeat (12) @(posedge clock);
      chk_pin({23'h0, cyc_ready}, 24'h1);
      cyc_in <= '0;
      cyc_three_state <= 1'b0;
    end
    // move every register off its reset value first
    wr(0, 8'h01);
    wr(1, 8'hf0);
    wr(2, 8'h00);
    for (int r = 0; r < 3; r++) rd(r);
    hw_standby <= 1'b1;
    repeat (2) @(posedge clock);
    hw_standby <= 1'b0;
    m[0] = 8'hc6;
    m[1] = 8'h0f;
    m[2] = 8'hff;
    for (int r = 0; r < 3; r++) rd(r);
    conclude();
  end
endmodule
